// ### pkg/pms_cfg.svh
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// Register field positions
`define PMS_VPP_HI 15
`define PMS_VPP_LO 7
`define PMS_ROM_SEL_BIT 6
`define PMS_OVERLAY_BIT 5
`define PMS_VISIBLE_BIT 4
`define PMS_DATA_ROM_BIT 3
`define PMS_CLK_DISABLE_BIT 2
`define PMS_MUL_SAT_BIT 1
`define PMS_STORE_SAT_BIT 0

// Reset values
`define PMS_VPP_RESET 9'h1ff
`define PMS_RESET_VECTOR 16'hff80

// Address map constants
`define PMS_PAGE0_LAST 16'h007f
`define PMS_DUAL_RAM_FIRST 16'h0080
`define PMS_DUAL_RAM_LAST 16'h9fff
`define PMS_LOWER_HALF_LAST 16'h7fff
`define PMS_ROM_FIRST 16'hc000
`define PMS_DATA_ROM_FIRST 16'hf000

// Saturation limits, 40-bit accumulator and 32-bit product
`define PMS_POS_MAX32 32'h7fffffff
`define PMS_NEG_MIN32 32'h80000000
`define PMS_ACC_SIGN_BIT 39
`define PMS_STORE_SIGN_BIT 15
`define PMS_STORE_MAX 16'h7fff
`define PMS_STORE_MIN 16'h8000

`endif

// ### pkg/pms_pkg.sv
package pms_pkg;

    // Decoded control fields of the mode register
    typedef struct packed {
        logic [8:0] vector_page_pointer;
        logic rom_map_select;
        logic ram_overlay_enable;
        logic address_visibility_enable;
        logic rom_in_data_enable;
        logic clock_output_disable;
        logic multiply_saturate_enable;
        logic store_saturate_enable;
    } pms_mode_t;

    // Where an access lands
    typedef enum logic [1:0] {
        PMS_TGT_EXTERNAL = 2'b00,
        PMS_TGT_ROM = 2'b01,
        PMS_TGT_RAM = 2'b10
    } pms_target_t;

    // Reset sequencing for the strap capture
    typedef enum logic [1:0] {
        PMS_ST_RESET = 2'b00,
        PMS_ST_CAPTURE = 2'b01,
        PMS_ST_RUN = 2'b10
    } pms_state_t;

endpackage

// ### hdl/pms_mode_ctrl.sv
`timescale 1ns/1ps
`include "pms_cfg.svh"
module pms_mode_ctrl
    import pms_pkg::*;
#(
    parameter int PAGE_BITS = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_pin,
    input wire logic soft_reset,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [PAGE_BITS-1:0] prog_page,
    input wire logic [15:0] prog_addr,
    input wire logic prog_fetch,
    input wire logic [6:0] vector_num,
    output logic [15:0] vector_addr,
    output logic [15:0] boot_addr,
    output pms_target_t prog_target,
    input wire logic [15:0] data_addr,
    output pms_target_t data_target,
    input wire logic [15:0] ext_addr_in,
    input wire logic ext_addr_valid,
    output logic [15:0] ext_addr_pins,
    input wire logic core_clock,
    output logic clock_output_pin,
    input wire logic overflow_saturate_mode,
    input wire logic fractional_multiply_mode,
    input wire logic [31:0] product_in,
    output logic [31:0] product_out,
    input wire logic [39:0] acc_shifted,
    output logic [15:0] store_data,
    output logic ready
);

    //**********************************************************
    // Mode register and reset sequencing
    //**********************************************************
    // Separate flop groups for pointer, ROM select and the remaining fields, so each field has exactly one writer
    logic [`PMS_VPP_HI-`PMS_VPP_LO:0] vector_page_pointer;
    logic rom_map_select;
    logic ram_overlay_enable;
    logic address_visibility_enable;
    logic rom_in_data_enable;
    logic clock_output_disable;
    logic multiply_saturate_enable;
    logic store_saturate_enable;
    pms_mode_t mode;
    pms_state_t state;
    pms_state_t next_state;

    // Strap is caught by a clocked step after release, never by the async reset
    always_comb begin
        next_state = state;
        case (state)
            PMS_ST_RESET: begin
                next_state = PMS_ST_CAPTURE;
            end
            PMS_ST_CAPTURE: begin
                next_state = PMS_ST_RUN;
            end
            PMS_ST_RUN: begin
                next_state = PMS_ST_RUN;
            end
            default: begin
                next_state = PMS_ST_RESET;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PMS_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Vector page pointer: only hardware reset restores it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_page_pointer <= `PMS_VPP_RESET;
        end else if (reg_wr && state == PMS_ST_RUN) begin
            vector_page_pointer <= reg_wdata[`PMS_VPP_HI:`PMS_VPP_LO];
        end
        // soft_reset deliberately has no effect here
    end

    // ROM map select: strap sampled once, then software owned
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_map_select <= 1'b0;
        end else if (state == PMS_ST_CAPTURE) begin
            rom_map_select <= mode_pin;
        end else if (reg_wr && state == PMS_ST_RUN) begin
            rom_map_select <= reg_wdata[`PMS_ROM_SEL_BIT];
        end
    end

    // Remaining fields reset to zero; software reset is a full-register no-op
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_overlay_enable <= 1'b0;
            address_visibility_enable <= 1'b0;
            rom_in_data_enable <= 1'b0;
            clock_output_disable <= 1'b0;
            multiply_saturate_enable <= 1'b0;
            store_saturate_enable <= 1'b0;
        end else if (reg_wr && state == PMS_ST_RUN) begin
            ram_overlay_enable <= reg_wdata[`PMS_OVERLAY_BIT];
            address_visibility_enable <= reg_wdata[`PMS_VISIBLE_BIT];
            rom_in_data_enable <= reg_wdata[`PMS_DATA_ROM_BIT];
            clock_output_disable <= reg_wdata[`PMS_CLK_DISABLE_BIT];
            multiply_saturate_enable <= reg_wdata[`PMS_MUL_SAT_BIT];
            store_saturate_enable <= reg_wdata[`PMS_STORE_SAT_BIT];
        end
    end

    // Packed view in register bit order, shared by read port and decoders
    assign mode = {
        vector_page_pointer,
        rom_map_select,
        ram_overlay_enable,
        address_visibility_enable,
        rom_in_data_enable,
        clock_output_disable,
        multiply_saturate_enable,
        store_saturate_enable
    };

    // Read port shows the live register
    assign reg_rdata = mode;
    // Writes before the strap is captured would be overwritten, so hold off
    assign ready = (state == PMS_ST_RUN);

    //**********************************************************
    // Vector and boot addressing
    //**********************************************************
    // Vector address is page base plus one word per vector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_addr <= `PMS_RESET_VECTOR;
        end else begin
            vector_addr <= {mode.vector_page_pointer, vector_num};
        end
    end

    // Reset always fetches from FF80h, in ROM when the strap was low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_addr <= `PMS_RESET_VECTOR;
        end else begin
            boot_addr <= `PMS_RESET_VECTOR;
        end
    end

    //**********************************************************
    // Program and data space decode
    //**********************************************************
    logic prog_low_half;
    logic prog_in_ram;
    logic prog_in_rom;

    // Lower 32K of any page holds overlay RAM, outside page 0 data area
    assign prog_low_half = (prog_addr <= `PMS_LOWER_HALF_LAST);
    assign prog_in_ram = mode.ram_overlay_enable && prog_low_half
        && (prog_addr >= `PMS_DUAL_RAM_FIRST)
        && (prog_addr <= `PMS_DUAL_RAM_LAST);
    // ROM only on page zero upper area; ROM beyond page zero left external here
    assign prog_in_rom = !mode.rom_map_select && (prog_page == '0)
        && (prog_addr >= `PMS_ROM_FIRST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_target <= PMS_TGT_EXTERNAL;
        end else if (prog_in_ram) begin
            prog_target <= PMS_TGT_RAM;
        end else if (prog_in_rom) begin
            prog_target <= PMS_TGT_ROM;
        end else begin
            prog_target <= PMS_TGT_EXTERNAL;
        end
    end

    logic data_in_ram;
    logic data_in_rom;

    // Dual-access RAM answers in data space whatever the overlay bit says
    assign data_in_ram = (data_addr >= `PMS_DUAL_RAM_FIRST)
        && (data_addr <= `PMS_DUAL_RAM_LAST);
    // Window start is a local choice; only the cleared case is pinned down
    assign data_in_rom = mode.rom_in_data_enable && (data_addr >= `PMS_DATA_ROM_FIRST);

    // Data space: RAM always, ROM window only with ROM-in-data set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_target <= PMS_TGT_EXTERNAL;
        end else if (data_in_ram) begin
            data_target <= PMS_TGT_RAM;
        end else if (data_in_rom) begin
            data_target <= PMS_TGT_ROM;
        end else begin
            data_target <= PMS_TGT_EXTERNAL;
        end
    end

    //**********************************************************
    // External address pins
    //**********************************************************
    // Hold last external address unless tracing internal fetches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_addr_pins <= 16'h0000;
        end else if (ext_addr_valid) begin
            // A real external cycle always owns the pins
            ext_addr_pins <= ext_addr_in;
        end else if (mode.address_visibility_enable && prog_fetch) begin
            ext_addr_pins <= prog_addr;
        end
        // Otherwise hold
    end

    //**********************************************************
    // Clock output pin
    //**********************************************************
    // Registered to keep the pin glitch free; costs one cycle of delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_output_pin <= 1'b1;
        end else if (mode.clock_output_disable) begin
            clock_output_pin <= 1'b1;
        end else begin
            // Tracks the core clock one cycle late
            clock_output_pin <= core_clock;
        end
    end

    //**********************************************************
    // Saturation datapaths
    //**********************************************************
    logic product_sat_on;
    logic product_ovf;
    logic store_hi;
    logic store_lo;

    assign product_sat_on = mode.multiply_saturate_enable
        && overflow_saturate_mode && fractional_multiply_mode;
    // Fractional 8000h x 8000h is the only overflowing product
    assign product_ovf = (product_in == `PMS_NEG_MIN32);

    // Registered so the product meets the accumulator in the next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            product_out <= 32'h00000000;
        end else if (product_sat_on && product_ovf) begin
            product_out <= `PMS_POS_MAX32;
        end else begin
            product_out <= product_in;
        end
    end

    logic acc_sign;
    logic [`PMS_ACC_SIGN_BIT-`PMS_STORE_SIGN_BIT-1:0] acc_guard;

    // Sign bit and the guard bits down to the stored word's sign
    assign acc_sign = acc_shifted[`PMS_ACC_SIGN_BIT];
    assign acc_guard = acc_shifted[`PMS_ACC_SIGN_BIT-1:`PMS_STORE_SIGN_BIT];
    // Input is already shifted, so clamping follows the shift
    assign store_hi = !acc_sign && (acc_guard != '0);
    assign store_lo = acc_sign && (acc_guard != '1);

    // Clamp only with store saturation on; otherwise pass the low word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_data <= 16'h0000;
        end else if (mode.store_saturate_enable && store_hi) begin
            store_data <= `PMS_STORE_MAX;
        end else if (mode.store_saturate_enable && store_lo) begin
            store_data <= `PMS_STORE_MIN;
        end else begin
            store_data <= acc_shifted[`PMS_STORE_SIGN_BIT:0];
        end
    end

endmodule

// ### sim/pms_mode_ctrl_properties.sv
`timescale 1ns/1ps
// ********************************
// Mode register port checker
// ********************************
module pms_mode_props
    import pms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic ready,
    input wire logic [6:0] vector_num,
    input wire logic [15:0] vector_addr,
    input wire logic [15:0] boot_addr,
    input wire logic core_clock,
    input wire logic clock_output_pin,
    input wire logic overflow_saturate_mode,
    input wire logic fractional_multiply_mode,
    input wire logic [31:0] product_in,
    input wire logic [31:0] product_out,
    input wire logic [15:0] data_addr,
    input pms_target_t data_target
);
    // All but p_boot gated by ready so the strap edges after reset never count
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_wr;
        reg_wr && ready |=> reg_rdata == $past(reg_wdata);
    endproperty
    a_wr: assert property (p_wr)
        else $error("register write not taken");
    property p_hold;
        ready && !reg_wr |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without a write");
    property p_vec;
        ready |=> vector_addr == {$past(reg_rdata[15:7]), $past(vector_num)};
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector address not from pointer");
    property p_boot;
        boot_addr == 16'hff80;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot address moved");
    property p_clk;
        ready |=> clock_output_pin == ($past(reg_rdata[2]) || $past(core_clock));
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock pin wrong");
    property p_mul_sat;
        ready && reg_rdata[1] && overflow_saturate_mode && fractional_multiply_mode
            && product_in == 32'h80000000 |=> product_out == 32'h7fffffff;
    endproperty
    a_mul_sat: assert property (p_mul_sat)
        else $error("product not saturated");
    property p_nosat;
        ready && !reg_rdata[1] |=> product_out == $past(product_in);
    endproperty
    a_nosat: assert property (p_nosat)
        else $error("product altered");
    property p_rom_data;
        ready && !reg_rdata[3] && data_addr >= 16'ha000 |=> data_target == PMS_TGT_EXTERNAL;
    endproperty
    a_rom_data: assert property (p_rom_data)
        else $error("rom seen in data space");
    property p_dual_ram;
        ready && data_addr inside {[16'h0080:16'h9fff]} |=> data_target == PMS_TGT_RAM;
    endproperty
    a_dual_ram: assert property (p_dual_ram)
        else $error("data ram not decoded");
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
// ********************************
// Mode register testbench
// ********************************
module tb
    import pms_pkg::*;
;
    // Decode row: register value, addresses, expected targets
    typedef struct {
        logic [15:0] pm;
        logic [6:0] pg;
        logic [15:0] pa;
        logic [15:0] da;
        pms_target_t ep;
        pms_target_t ed;
    } pms_row_t;
    logic clk = 0, rst_n = 0, mode_pin = 1, soft_reset = 0, reg_wr = 0, prog_fetch = 0;
    logic ext_addr_valid = 0, core_clock = 0;
    logic overflow_saturate_mode = 0, fractional_multiply_mode = 0;
    logic [15:0] reg_wdata = '0, prog_addr = '0, data_addr = '0, ext_addr_in = '0;
    logic [6:0] prog_page = '0, vector_num = '0;
    logic [31:0] product_in = '0, product_out;
    logic [39:0] acc_shifted = '0;
    logic [15:0] reg_rdata, vector_addr, boot_addr, ext_addr_pins, store_data;
    logic clock_output_pin, ready;
    pms_target_t prog_target, data_target;
    int n_mismatch = 0, n_compared = 0;
    logic [39:0] accs[4] = '{40'h0000012345, 40'hffffff0000, 40'h0000001234, 40'h0000012345};
    logic [15:0] sts[4] = '{16'h7fff, 16'h8000, 16'h1234, 16'h2345};
    pms_row_t rows[6] = '{
        '{16'hff80, 7'h00, 16'hc000, 16'h0080, PMS_TGT_ROM, PMS_TGT_RAM},
        '{16'hffa0, 7'h05, 16'h0080, 16'h007f, PMS_TGT_RAM, PMS_TGT_EXTERNAL},
        '{16'hffa0, 7'h00, 16'h007f, 16'h9fff, PMS_TGT_EXTERNAL, PMS_TGT_RAM},
        '{16'hffc0, 7'h00, 16'hffff, 16'hf000, PMS_TGT_EXTERNAL, PMS_TGT_EXTERNAL},
        '{16'hff88, 7'h01, 16'hc000, 16'hf000, PMS_TGT_EXTERNAL, PMS_TGT_ROM},
        '{16'hff80, 7'h00, 16'h0080, 16'ha000, PMS_TGT_EXTERNAL, PMS_TGT_EXTERNAL}
    };
    pms_mode_ctrl dut_u (.clk, .rst_n, .mode_pin, .soft_reset, .reg_wr, .reg_wdata,
        .reg_rdata, .prog_page, .prog_addr, .prog_fetch, .vector_num, .vector_addr,
        .boot_addr, .prog_target, .data_addr, .data_target, .ext_addr_in,
        .ext_addr_valid, .ext_addr_pins, .core_clock, .clock_output_pin,
        .overflow_saturate_mode, .fractional_multiply_mode, .product_in, .product_out,
        .acc_shifted, .store_data, .ready);
    // Clocks; the reflected clock toggles every cycle so any delay error shows
    initial forever #20 clk = ~clk;
    always @(posedge clk) core_clock <= ~core_clock;
    // Hang guard, far above the longest sequence
    initial begin
        #200000;
        n_mismatch++;
        summarize;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wt;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic hrst(logic mp);
        @(posedge clk);
        rst_n <= 1'b0;
        mode_pin <= mp;
        wt;
        chk("rst rdata", 32'hff80, reg_rdata);
        chk("rst vector", 32'hff80, vector_addr);
        chk("rst clk pin", 32'h1, clock_output_pin);
        @(posedge clk);
        rst_n <= 1'b1;
        wt;
        chk("ready early", 32'h0, ready);
        repeat (8) if (ready !== 1'b1) wt;
        if (ready !== 1'b1) begin
            n_mismatch++;
            summarize;
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: reset and strap checks, then table, then hand-written cases
    initial begin
        hrst(1'b1);
        chk("strap high", 32'hffc0, reg_rdata);
        @(posedge clk);
        mode_pin <= 1'b0;
        wt;
        chk("no resample", 32'hffc0, reg_rdata);
        foreach (rows[i]) begin
            wr(rows[i].pm);
            @(posedge clk);
            prog_page <= rows[i].pg;
            prog_addr <= rows[i].pa;
            data_addr <= rows[i].da;
            wt;
            chk("prog target", rows[i].ep, prog_target);
            chk("data target", rows[i].ed, data_target);
        end
        $display("decode table done");
        wr(16'h1234);
        chk("readback", 32'h1234, reg_rdata);
        @(posedge clk);
        soft_reset <= 1'b1;
        vector_num <= 7'h08;
        @(posedge clk);
        soft_reset <= 1'b0;
        wt;
        chk("soft reset", 32'h1234, reg_rdata);
        chk("vector", 32'h1208, vector_addr);
        chk("boot", 32'hff80, boot_addr);
        $display("soft reset and vector done");
        // External access latches, then hidden fetches must not move the pins
        wr(16'hff80);
        @(posedge clk);
        ext_addr_valid <= 1'b1;
        ext_addr_in <= 16'habcd;
        prog_fetch <= 1'b1;
        prog_addr <= 16'h1111;
        @(posedge clk);
        ext_addr_valid <= 1'b0;
        wt;
        chk("pins held", 32'habcd, ext_addr_pins);
        wr(16'hff90);
        wt;
        chk("pins trace", 32'h1111, ext_addr_pins);
        wr(16'hff84);
        repeat (2) begin
            wt;
            chk("clk off", 32'h1, clock_output_pin);
        end
        wr(16'hff80);
        repeat (2) begin
            wt;
            chk("clk on", {31'h0, ~core_clock}, clock_output_pin);
        end
        $display("pins and clock done");
        @(posedge clk);
        product_in <= 32'h80000000;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            overflow_saturate_mode <= i[0];
            fractional_multiply_mode <= i[1];
            wr({14'h3fe0, i[2], 1'b0});
            wt;
            chk("product", (i == 7) ? 32'h7fffffff : 32'h80000000, product_out);
        end
        wr(16'hff81);
        for (int i = 0; i < 4; i++) begin
            if (i == 3)
                wr(16'hff80);
            @(posedge clk);
            acc_shifted <= accs[i];
            wt;
            chk("store", {16'h0, sts[i]}, store_data);
        end
        $display("saturation done");
        hrst(1'b0);
        chk("strap low", 32'hff80, reg_rdata);
        $display("second reset done");
        summarize;
    end
endmodule
bind pms_mode_ctrl pms_mode_props chk_u (.clk, .rst_n, .reg_wr, .reg_wdata, .reg_rdata,
    .ready, .vector_num, .vector_addr, .boot_addr, .core_clock, .clock_output_pin,
    .overflow_saturate_mode, .fractional_multiply_mode, .product_in, .product_out,
    .data_addr, .data_target);
